// [cpc_config_bank.sv]
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// R01 - Ingress level bit selects link level two
// R02 - Egress level bit selects link level two
// R03 - Extension table present only when bit set
// R04 - Byte with cell start is byte zero
// R05 - Bit seven is MSB, bit zero LSB
// R06 - Egress CLP taken at programmed byte/bit
// R07 - Ingress flow status at programmed byte/bit
// R08 - Egress flow status at programmed byte/bit
// R09 - Backward RM overlay only when enabled
// R10 - Forward RM overlay only when enabled
// R11 - Overlay only the selected parameter byte
// R12 - Masked bits replaced, unmasked bits kept
// R13 - Ingress CLP placed, byte zero is MSB
// R14 - Table pointer counts 256-byte units
// R15 - M bit: pass, invert, zero, one
// R16 - Tag width: 0 full, else LSBs
// R17 - Conn index width: 0 full, 6-15 LSBs
// R18 - Fixed-zero bits read zero, ignore writes
module cpc_config_bank
  import cpc_pkg::*;
#(
  parameter int TAG_W  = 4,
  parameter int CID_W  = 16,
  parameter int BASE_W = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic                      ingress_link_level_sel,
  output logic                      egress_link_level_sel,
  output logic                      ext_table_present,
  output logic      [BASE_W-1:0]    ext_table_base_addr,
  input  wire logic                 sw_byte_valid,
  input  wire logic                 switch_tx_cell_start,
  input  wire logic [7:0]           sw_byte,
  output logic                      egr_overhead_loss_prio,
  output logic                      ing_flow_status,
  output logic                      egr_flow_status,
  input  wire logic                 ing_param_valid,
  input  wire logic                 ing_is_backward_rm,
  input  wire logic                 ing_is_forward_rm,
  input  wire logic                 ing_clp_insert,
  input  wire logic                 ing_overhead_loss_prio,
  input  wire logic [31:0]          ing_param_in,
  output logic                      ing_param_valid_out,
  output logic      [31:0]          ing_param_out,
  input  wire logic                 egr_valid,
  input  wire logic                 egr_m_bit_in,
  input  wire logic [TAG_W-1:0]     multicast_tag_field,
  input  wire logic [CID_W-1:0]     egress_conn_index,
  output logic                      egr_valid_out,
  output logic                      egr_m_bit,
  output logic      [TAG_W-1:0]     egr_tag_used,
  output logic      [CID_W-1:0]     egr_conn_index_used
);

  logic [31:0] regs [NUM_REGS];
  logic [5:0]  byte_cnt;
  logic [5:0]  cur_idx;
  logic        setup;
  logic        wr_acc;
  logic [2:0]  hit_idx;
  logic        hit;
  logic [31:0] ovl_word;
  logic [31:0] clp_word;

  function automatic logic [31:0] reg_mask(input int idx);
    case (idx)
      IDX_ING_PHY:  reg_mask = MSK_ING_PHY;
      IDX_EGR_PHY:  reg_mask = MSK_EGR_PHY;
      IDX_GENERAL:  reg_mask = MSK_GENERAL;
      IDX_EGR_OHL1: reg_mask = MSK_EGR_OHL1;
      IDX_RM_OVL:   reg_mask = MSK_RM_OVL;
      IDX_CLP_LOC:  reg_mask = MSK_CLP_LOC;
      IDX_EXT_PTR:  reg_mask = MSK_EXT_PTR;
      default:      reg_mask = MSK_EGR_OHM;
    endcase
  endfunction : reg_mask

  // Bit position in a 32-bit word: byte 0 most significant, bit 7 MSB of byte
  function automatic logic [4:0] word_pos(input logic [1:0] byte_no, input logic [2:0] bit_no);
    word_pos = {2'h3 - byte_no, bit_no};
  endfunction : word_pos

  function automatic logic [CID_W-1:0] lsb_keep(input logic [3:0] n);
    logic [CID_W-1:0] m;
    m = '1;
    if (n != 4'h0) begin
      m = ~({CID_W{1'b1}} << n);
    end
    lsb_keep = m;
  endfunction : lsb_keep

  // APB decode
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite && pready;
  assign hit     = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0);
  assign hit_idx = paddr[4:2];

  // Zero wait states; pready is high from the first edge after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // Read data and error are prepared in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !hit;
      prdata  <= (hit && !pwrite) ? regs[hit_idx] : 32'h0000_0000;
    end
  end

  generate
    for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
      localparam logic [31:0] LANE_MSK = reg_mask(g);
      always_ff @(posedge clk) begin
        if (rst) begin
          regs[g] <= RST_VAL;
        end else if (wr_acc && hit && hit_idx == 3'(g)) begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
              regs[g][8*b +: 8] <= pwdata[8*b +: 8] & LANE_MSK[8*b +: 8]; // R18
            end
          end
        end
      end
    end
  endgenerate

  // Static configuration outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      ingress_link_level_sel <= 1'b0;
      egress_link_level_sel  <= 1'b0;
      ext_table_present      <= 1'b0;
      ext_table_base_addr    <= '0;
    end else begin
      ingress_link_level_sel <= regs[IDX_ING_PHY][POS_LVL_SEL]; // R01
      egress_link_level_sel  <= regs[IDX_EGR_PHY][POS_LVL_SEL]; // R02
      ext_table_present      <= regs[IDX_GENERAL][POS_EXT_PRES]; // R03
      ext_table_base_addr    <= BASE_W'({regs[IDX_EXT_PTR][POS_PTR +: PTR_W],
                                        {PTR_UNIT_LOG2{1'b0}}}); // R14
    end
  end

  // Switch-side byte index; the start byte is index zero
  assign cur_idx = switch_tx_cell_start ? 6'h00 : byte_cnt; // R04

  always_ff @(posedge clk) begin
    if (rst) begin
      byte_cnt <= '0;
    end else if (sw_byte_valid) begin
      // Saturates so a long structure cannot alias back onto a low byte
      byte_cnt <= (cur_idx == 6'h3f) ? cur_idx : cur_idx + 6'h01; // R04
    end
  end

  // Overhead bit extraction, updated when the programmed byte passes
  always_ff @(posedge clk) begin
    if (rst) begin
      egr_overhead_loss_prio <= 1'b0;
      ing_flow_status        <= 1'b0;
      egr_flow_status        <= 1'b0;
    end else if (sw_byte_valid) begin
      if (cur_idx == {1'b0, regs[IDX_EGR_OHL1][POS_EGR_CLP_BYTE +: 5]}) begin
        egr_overhead_loss_prio <= sw_byte[regs[IDX_EGR_OHL1][POS_EGR_CLP_BIT +: 3]]; // R06 R05
      end
      if (cur_idx == {1'b0, regs[IDX_EGR_OHL1][POS_ING_FLOW_BYTE +: 5]}) begin
        ing_flow_status <= sw_byte[regs[IDX_EGR_OHL1][POS_ING_FLOW_BIT +: 3]]; // R07 R05
      end
      if (cur_idx == {1'b0, regs[IDX_EGR_OHL1][POS_EGR_FLOW_BYTE +: 5]}) begin
        egr_flow_status <= sw_byte[regs[IDX_EGR_OHL1][POS_EGR_FLOW_BIT +: 3]]; // R08 R05
      end
    end
  end

  // RM overlay on ingress switch parameters
  always_comb begin
    logic       do_ovl;
    logic [7:0] msk;
    logic [7:0] val;
    do_ovl   = (ing_is_backward_rm && regs[IDX_RM_OVL][POS_BRM_EN]) // R09
            || (ing_is_forward_rm && regs[IDX_RM_OVL][POS_FRM_EN]); // R10
    msk      = regs[IDX_RM_OVL][POS_OVL_MASK +: 8];
    val      = regs[IDX_RM_OVL][POS_OVL_VAL +: 8];
    ovl_word = ing_param_in;
    for (int b = 0; b < 4; b++) begin
      // Selections beyond the word leave it untouched
      if (do_ovl && regs[IDX_RM_OVL][POS_OVL_SEL +: 4] == 4'(b)) begin // R11
        ovl_word[8*(3-b) +: 8] = (ing_param_in[8*(3-b) +: 8] & ~msk) | (val & msk); // R12
      end
    end
  end

  // Ingress CLP placement after the overlay
  always_comb begin
    clp_word = ovl_word;
    if (ing_clp_insert) begin
      clp_word[word_pos(regs[IDX_CLP_LOC][POS_ING_CLP_BYTE +: 2],
                        regs[IDX_CLP_LOC][POS_ING_CLP_BIT +: 3])] = ing_overhead_loss_prio; // R13 R05
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ing_param_valid_out <= 1'b0;
      ing_param_out       <= '0;
    end else begin
      ing_param_valid_out <= ing_param_valid;
      if (ing_param_valid) begin
        ing_param_out <= clp_word;
      end
    end
  end

  // Egress M bit, tag and connection index selection
  always_ff @(posedge clk) begin
    if (rst) begin
      egr_valid_out       <= 1'b0;
      egr_m_bit           <= 1'b0;
      egr_tag_used        <= '0;
      egr_conn_index_used <= '0;
    end else begin
      egr_valid_out <= egr_valid;
      if (egr_valid) begin
        case (regs[IDX_EGR_OHM][POS_MSRC +: 2]) // R15
          MSRC_PASS: egr_m_bit <= egr_m_bit_in;
          MSRC_INV:  egr_m_bit <= !egr_m_bit_in;
          MSRC_ZERO: egr_m_bit <= 1'b0;
          MSRC_ONE:  egr_m_bit <= 1'b1;
          default:   egr_m_bit <= egr_m_bit_in;
        endcase
        egr_tag_used <= multicast_tag_field
                      & TAG_W'(lsb_keep({2'h0, regs[IDX_EGR_OHM][POS_TAG_W +: 2]})); // R16
        // Reserved widths fall back to the full field
        if (regs[IDX_EGR_OHM][POS_CID_W +: 4] >= CID_W_MIN) begin
          egr_conn_index_used <= egress_conn_index
                               & lsb_keep(regs[IDX_EGR_OHM][POS_CID_W +: 4]); // R17
        end else begin
          egr_conn_index_used <= egress_conn_index; // R17
        end
      end
    end
  end

endmodule : cpc_config_bank

// [cpc_pkg.sv]
package cpc_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          NUM_REGS      = 8;
  // Register byte offsets
  localparam logic [7:0]  OFS_ING_PHY   = 8'h00;
  localparam logic [7:0]  OFS_EGR_PHY   = 8'h04;
  localparam logic [7:0]  OFS_GENERAL   = 8'h08;
  localparam logic [7:0]  OFS_EGR_OHL1  = 8'h0c;
  localparam logic [7:0]  OFS_RM_OVL    = 8'h10;
  localparam logic [7:0]  OFS_CLP_LOC   = 8'h14;
  localparam logic [7:0]  OFS_EXT_PTR   = 8'h18;
  localparam logic [7:0]  OFS_EGR_OHM   = 8'h1c;
  // Register indices
  localparam int          IDX_ING_PHY   = 0;
  localparam int          IDX_EGR_PHY   = 1;
  localparam int          IDX_GENERAL   = 2;
  localparam int          IDX_EGR_OHL1  = 3;
  localparam int          IDX_RM_OVL    = 4;
  localparam int          IDX_CLP_LOC   = 5;
  localparam int          IDX_EXT_PTR   = 6;
  localparam int          IDX_EGR_OHM   = 7;
  // Writable bit masks; all other bits are fixed zero
  localparam logic [31:0] MSK_ING_PHY   = 32'h0000_001f;
  localparam logic [31:0] MSK_EGR_PHY   = 32'h0000_001f;
  localparam logic [31:0] MSK_GENERAL   = 32'h0001_0049;
  localparam logic [31:0] MSK_EGR_OHL1  = 32'h00ff_ffff;
  localparam logic [31:0] MSK_RM_OVL    = 32'hcfff_00ff;
  localparam logic [31:0] MSK_CLP_LOC   = 32'h0000_007f;
  localparam logic [31:0] MSK_EXT_PTR   = 32'h00ff_ff00;
  localparam logic [31:0] MSK_EGR_OHM   = 32'h0000_00ff;
  localparam logic [31:0] RST_VAL       = 32'h0000_0000;
  // Field positions
  localparam int          POS_LVL_SEL   = 4;
  localparam int          POS_EXT_PRES  = 6;
  localparam int          POS_EGR_CLP_BYTE  = 19;
  localparam int          POS_EGR_CLP_BIT   = 16;
  localparam int          POS_ING_FLOW_BYTE = 11;
  localparam int          POS_ING_FLOW_BIT  = 8;
  localparam int          POS_EGR_FLOW_BYTE = 3;
  localparam int          POS_EGR_FLOW_BIT  = 0;
  localparam int          POS_BRM_EN    = 31;
  localparam int          POS_FRM_EN    = 30;
  localparam int          POS_OVL_SEL   = 24;
  localparam int          POS_OVL_MASK  = 16;
  localparam int          POS_OVL_VAL   = 0;
  localparam int          POS_ING_CLP_BIT   = 4;
  localparam int          POS_ING_CLP_BYTE  = 0;
  localparam int          POS_PTR       = 8;
  localparam int          PTR_W         = 16;
  localparam int          PTR_UNIT_LOG2 = 8;
  localparam int          POS_MSRC      = 6;
  localparam int          POS_TAG_W     = 4;
  localparam int          POS_CID_W     = 0;
  localparam logic [1:0]  MSRC_PASS     = 2'h0;
  localparam logic [1:0]  MSRC_INV      = 2'h1;
  localparam logic [1:0]  MSRC_ZERO     = 2'h2;
  localparam logic [1:0]  MSRC_ONE      = 2'h3;
  localparam logic [3:0]  CID_W_MIN     = 4'h6;
endpackage : cpc_pkg

// [cpc_config_bank_assertions.sv]
`timescale 1ns/1ps
module cpc_config_bank_chk
  import cpc_pkg::*;
#(
  parameter int BASE_W = 32
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              ingress_link_level_sel,
  input wire logic              ext_table_present,
  input wire logic [BASE_W-1:0] ext_table_base_addr,
  input wire logic              sw_byte_valid,
  input wire logic              egr_flow_status,
  input wire logic              ing_param_valid,
  input wire logic              ing_param_valid_out,
  input wire logic              egr_valid,
  input wire logic              egr_valid_out
);
  logic wr;
  logic rd;
  // Full byte strobes assumed, as the bench always drives them
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && !penable && !pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ing_level_a: assert property (wr && paddr == OFS_ING_PHY
    |-> ##2 ingress_link_level_sel == $past(pwdata[POS_LVL_SEL], 2))
    else $error("level select wrong");
  ext_present_a: assert property (wr && paddr == OFS_GENERAL
    |-> ##2 ext_table_present == $past(pwdata[POS_EXT_PRES], 2))
    else $error("table present wrong");
  table_base_a: assert property (wr && paddr == OFS_EXT_PTR
    |-> ##2 ext_table_base_addr == {8'h00, $past(pwdata[23:8], 2), 8'h00})
    else $error("base wrong");
  unmapped_err_a: assert property (rd && (paddr >= 8'h20 || paddr[1:0] != 2'h0)
    |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  fixed_zero_a: assert property (rd && paddr == OFS_ING_PHY
    |=> !pslverr && (prdata & ~MSK_ING_PHY) == 32'h0) else $error("fixed bits not zero");
  flow_hold_a: assert property (!sw_byte_valid |=> $stable(egr_flow_status))
    else $error("flow status moved without a byte");
  egr_pulse_a: assert property (egr_valid |=> egr_valid_out)
    else $error("egress result missing");
  ing_pulse_a: assert property ($rose(ing_param_valid_out) |-> $past(ing_param_valid))
    else $error("ingress result without request");
  cover property (wr && paddr == OFS_RM_OVL);
  cover property (rd && paddr >= 8'h20);
  cover property (egr_valid ##1 egr_valid_out);
endmodule : cpc_config_bank_chk

bind cpc_config_bank cpc_config_bank_chk #(.BASE_W(BASE_W)) i_chk (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ingress_link_level_sel,
  .ext_table_present, .ext_table_base_addr, .sw_byte_valid, .egr_flow_status,
  .ing_param_valid, .ing_param_valid_out, .egr_valid, .egr_valid_out);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import cpc_pkg::*;
;
  typedef struct {logic [7:0] ohm; logic m; logic em; logic [3:0] et; logic [15:0] ec;} cpc_row_s;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, sw_byte;
  logic [3:0]  pstrb, multicast_tag_field, egr_tag_used;
  logic [15:0] egress_conn_index, egr_conn_index_used;
  logic [31:0] pwdata, prdata, ing_param_in, ing_param_out, ext_table_base_addr, r;
  logic        ingress_link_level_sel, egress_link_level_sel, ext_table_present;
  logic        sw_byte_valid, switch_tx_cell_start, egr_overhead_loss_prio, ing_flow_status;
  logic        egr_flow_status, ing_param_valid, ing_is_backward_rm, ing_is_forward_rm;
  logic        ing_clp_insert, ing_overhead_loss_prio, ing_param_valid_out, egr_valid;
  logic        egr_m_bit_in, egr_valid_out, egr_m_bit;
  int          err_count = 0;
  int          checked = 0;
  logic [31:0] msk [8] = '{MSK_ING_PHY, MSK_EGR_PHY, MSK_GENERAL, MSK_EGR_OHL1,
                           MSK_RM_OVL, MSK_CLP_LOC, MSK_EXT_PTR, MSK_EGR_OHM};
  logic [7:0]  swb [6] = '{8'h01, 8'h7e, 8'h80, 8'h7f, 8'hf7, 8'h08};
  cpc_row_s    rows [5] = '{'{8'h00, 1'b1, 1'b1, 4'hb, 16'ha5c3},
    '{8'h55, 1'b1, 1'b0, 4'h1, 16'ha5c3}, '{8'ha6, 1'b1, 1'b0, 4'h3, 16'h0003},
    '{8'hff, 1'b0, 1'b1, 4'h3, 16'h25c3}, '{8'h40, 1'b0, 1'b1, 4'hb, 16'ha5c3}};

  cpc_config_bank i_dut (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .ingress_link_level_sel, .egress_link_level_sel, .ext_table_present,
    .ext_table_base_addr, .sw_byte_valid, .switch_tx_cell_start, .sw_byte,
    .egr_overhead_loss_prio, .ing_flow_status, .egr_flow_status, .ing_param_valid,
    .ing_is_backward_rm, .ing_is_forward_rm, .ing_clp_insert, .ing_overhead_loss_prio,
    .ing_param_in, .ing_param_valid_out, .ing_param_out, .egr_valid, .egr_m_bit_in,
    .multicast_tag_field, .egress_conn_index, .egr_valid_out, .egr_m_bit, .egr_tag_used,
    .egr_conn_index_used
  );
  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic ing(input logic b, input logic f, input logic c, input logic [31:0] p, x);
    ing_param_valid <= 1'b1;
    ing_is_backward_rm <= b;
    ing_is_forward_rm <= f;
    ing_clp_insert <= c;
    ing_overhead_loss_prio <= c;
    ing_param_in <= p;
    @(posedge clk);
    ing_param_valid <= 1'b0;
    #1;
    chk(ing_param_out, x);
    chk(ing_param_valid_out, 1'b1);
    @(posedge clk);
  endtask : ing

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  initial begin
    #50000;
    err_count++;
    summarize();
  end

  initial begin
    {clk, rst, pstrb} = 6'h1f;
    {psel, penable, pwrite, paddr, pwdata, sw_byte, sw_byte_valid, switch_tx_cell_start} = '0;
    {ing_param_valid, ing_is_backward_rm, ing_is_forward_rm, ing_clp_insert} = '0;
    {ing_overhead_loss_prio, ing_param_in, egr_valid, egr_m_bit_in} = '0;
    {multicast_tag_field, egress_conn_index} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    foreach (rows[i]) begin
      apb(OFS_EGR_OHM, 1'b1, {24'h0, rows[i].ohm});
      egr_valid <= 1'b1;
      egr_m_bit_in <= rows[i].m;
      multicast_tag_field <= 4'hb;
      egress_conn_index <= 16'ha5c3;
      @(posedge clk);
      egr_valid <= 1'b0;
      #1;
      chk(egr_valid_out, 1'b1);
      chk(egr_m_bit, rows[i].em);
      chk(egr_tag_used, rows[i].et);
      chk(egr_conn_index_used, rows[i].ec);
      @(posedge clk);
    end
    // Second reset in mid-run must clear everything written above
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({ingress_link_level_sel, egress_link_level_sel, ext_table_present}, 3'h0);
    for (int i = 0; i < 8; i++) begin
      apb(8'(i * 4), 1'b0, 32'h0);
      chk(r, RST_VAL);
      chk(e, 1'b0);
      apb(8'(i * 4), 1'b1, 32'hffff_ffff);
      apb(8'(i * 4), 1'b0, 32'h0);
      chk(r, msk[i]);
    end
    chk({ingress_link_level_sel, egress_link_level_sel, ext_table_present}, 3'h7);
    chk(ext_table_base_addr, 32'h00ff_ff00);
    apb(8'h20, 1'b0, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    apb(8'h06, 1'b0, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    apb(OFS_EGR_OHL1, 1'b1, 32'h0017_002b);
    foreach (swb[k]) begin
      sw_byte_valid <= 1'b1;
      switch_tx_cell_start <= (k == 0);
      sw_byte <= swb[k];
      @(posedge clk);
    end
    sw_byte_valid <= 1'b0;
    repeat (2) @(posedge clk);
    chk(egr_overhead_loss_prio, 1'b1);
    chk({ing_flow_status, egr_flow_status}, 2'h3);
    apb(OFS_RM_OVL, 1'b1, 32'h810f_00a5);
    apb(OFS_CLP_LOC, 1'b1, 32'h0000_0023);
    ing(1'b1, 1'b0, 1'b0, 32'h1234_5678, 32'h1235_5678);
    ing(1'b0, 1'b1, 1'b0, 32'h1234_5678, 32'h1234_5678);
    ing(1'b0, 1'b0, 1'b1, 32'h0, 32'h0000_0004);
    apb(OFS_RM_OVL, 1'b1, 32'h410f_00a5);
    ing(1'b0, 1'b1, 1'b0, 32'h1234_5678, 32'h1235_5678);
    ing(1'b1, 1'b0, 1'b0, 32'h1234_5678, 32'h1234_5678);
    summarize();
  end
endmodule : tb_top
